// ==== src/pei_irq_logic.sv ====
// Purpose: event flags, enable mask and active-low interrupt of the phy
// Assumes: register file host supplies read strobes and 16-bit write data
// Notes:   sources are raw status bits, crossed into mclk before use
//
// Operation
// RQ1: active-low interrupt pin on enabled events
// RQ2: alternate select resets to zero
// RQ3: software sets alternate select after reset
// RQ4: both modes assert the same way
// RQ5: mask bits 7..1 pair with flags
// RQ6: rising edge sets, link down falling
// RQ7: default mode releases on deassert event
// RQ8: source fall or flag read clears
// RQ9: page and parallel fault extra clears
// RQ10: late 256 ms pulse after energy falls
// RQ11: energy service routine clears its mask
// RQ12: energy and its flag start high
// RQ13: alternate mode mask clear releases output
// RQ14: write one checks deassert condition
// RQ15: condition is source low, link high
// RQ16: output low while enabled flag set
`timescale 1ns/100ps
`default_nettype none
`include "pei_defs.svh"
module pei_irq_logic #(
   parameter int unsigned PULSE_CYCLES = `PEI_PULSE_CYCLES,
   parameter int unsigned DELAY_CYCLES = `PEI_DELAY_CYCLES
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire pei_pkg::pei_src_t src_async,
   input  wire logic              neg_restart,
   input  wire logic              alt_release_mode_sel,
   input  wire logic              reg_rd,
   input  wire logic              reg_wr,
   input  wire logic [4:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   output logic [15:0]            reg_rdata,
   output logic                   irq_out_low
);
   import pei_pkg::*;

   pei_src_t  lvl;
   pei_src_t  rise;
   pei_src_t  fall;
   pei_src_t  flags;
   pei_src_t  enables;
   pei_src_t  next_flags;
   pei_src_t  set_ev;
   pei_src_t  clr_ev;
   pei_src_t  deassert_ok;
   pei_late_t late_st;
   logic [31:0] late_cnt;
   logic        late_armed;
   logic        late_pulse;
   logic        link_down_ev;

   pei_edge_sync u_sync (
      .mclk      (mclk),
      .rst       (rst),
      .src_async (src_async),
      .src_level (lvl),
      .src_rise  (rise),
      .src_fall  (fall)
   );

   function automatic logic is_read(input logic [4:0] a, input logic [4:0] which);
      is_read = reg_rd && (a == which);
   endfunction

   assign link_down_ev = fall[`PEI_BIT_LINKDOWN];

   always_comb begin
      set_ev = rise;                                        // [RQ6]
      set_ev[`PEI_BIT_LINKDOWN] = fall[`PEI_BIT_LINKDOWN];  // [RQ6]
      deassert_ok = ~lvl;                                   // [RQ15]
      deassert_ok[`PEI_BIT_LINKDOWN] = lvl[`PEI_BIT_LINKDOWN]; // [RQ15]
      clr_ev = 7'h00;
      if (!alt_release_mode_sel) begin                      // [RQ2]
         clr_ev = fall;                                     // [RQ8]
         clr_ev[`PEI_BIT_LINKDOWN] = 1'b0;                  // [RQ8]
         if (is_read(reg_addr, `PEI_REG_EVENT_FLAGS))
            clr_ev = 7'h7f;                                 // [RQ8] [RQ7]
         if (is_read(reg_addr, `PEI_REG_BASIC_STATUS)) begin
            clr_ev[`PEI_BIT_RFAULT]   = 1'b1;               // [RQ8]
            clr_ev[`PEI_BIT_LINKDOWN] = 1'b1;               // [RQ8]
         end
         if (is_read(reg_addr, `PEI_REG_NEG_EXPANSION) || neg_restart || link_down_ev) begin
            clr_ev[`PEI_BIT_PDFAULT] = 1'b1;                // [RQ9]
            clr_ev[`PEI_BIT_PAGE]    = 1'b1;                // [RQ9]
         end
      end else if (reg_wr && reg_addr == `PEI_REG_EVENT_FLAGS) begin
         clr_ev = reg_wdata[7:1] & deassert_ok;             // [RQ14]
      end
      next_flags = (flags & ~clr_ev) | set_ev;              // set wins over clear
   end

   // energy flag starts high since energy detect reads high at acquisition start
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         flags <= 7'h40;                                    // [RQ12]
      else
         flags <= next_flags;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         enables <= 7'h00;
      else if (reg_wr && reg_addr == `PEI_REG_ENABLE_BITS)
         enables <= reg_wdata[7:1];                         // [RQ5]
   end

   // late energy pulse: release while energy still high arms it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         late_st    <= PEI_LATE_IDLE;
         late_cnt   <= 32'h0;
         late_armed <= 1'b0;
      end else begin
         if (flags[`PEI_BIT_ENERGY] && !next_flags[`PEI_BIT_ENERGY] && lvl[`PEI_BIT_ENERGY])
            late_armed <= enables[`PEI_BIT_ENERGY];
         case (late_st)
            PEI_LATE_IDLE: begin
               if (late_armed && fall[`PEI_BIT_ENERGY]) begin
                  late_st    <= PEI_LATE_WAIT;
                  late_cnt   <= 32'h0;
                  late_armed <= 1'b0;
               end
            end
            PEI_LATE_WAIT: begin
               if (late_cnt >= DELAY_CYCLES - 1) begin
                  late_st  <= PEI_LATE_PULSE;
                  late_cnt <= 32'h0;
               end else
                  late_cnt <= late_cnt + 32'h1;
            end
            PEI_LATE_PULSE: begin
               if (late_cnt >= PULSE_CYCLES - 1 || !enables[`PEI_BIT_ENERGY])
                  late_st <= PEI_LATE_IDLE;                 // [RQ10]
               else
                  late_cnt <= late_cnt + 32'h1;
            end
            default: late_st <= PEI_LATE_IDLE;
         endcase
      end
   end
   assign late_pulse = (late_st == PEI_LATE_PULSE);

   // registered output; alt mode releases one cycle after the mask clears
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         irq_out_low <= 1'b1;
      else
         irq_out_low <= !(|(next_flags & enables) || late_pulse); // [RQ1] [RQ4] [RQ13] [RQ16]
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd) begin
         case (reg_addr)
            `PEI_REG_EVENT_FLAGS: reg_rdata <= {8'h00, flags, 1'b0};
            `PEI_REG_ENABLE_BITS: reg_rdata <= {8'h00, enables, 1'b0};
            default:              reg_rdata <= 16'h0000;
         endcase
      end
   end

   // pin follows the flags in the same cycle but lags the mask by one cycle, so judge it only under a steady mask
   a_irq_tracks_flags: assert property (@(posedge mclk) disable iff (rst) // [RQ16]
      ((|(flags & enables)) && $stable(enables)) |-> !irq_out_low)
      else $error("interrupt not low with enabled flag");
   a_irq_released: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      (!(|(flags & enables)) && $stable(enables) && !$past(late_pulse)) |-> irq_out_low)
      else $error("interrupt low with no enabled flag");
   a_set_link_down: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
      fall[`PEI_BIT_LINKDOWN] |=> flags[`PEI_BIT_LINKDOWN])
      else $error("link down flag not set");
   a_set_on_rise: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
      rise[`PEI_BIT_ACK] |=> flags[`PEI_BIT_ACK])
      else $error("rising source did not set flag");
   a_read_clears: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      (!alt_release_mode_sel && reg_rd && reg_addr == `PEI_REG_EVENT_FLAGS && !(|set_ev))
      |=> flags == 7'h00)
      else $error("flag read did not clear");
   a_fall_clears: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      (!alt_release_mode_sel && fall[`PEI_BIT_NEG_DONE]) |=> !flags[`PEI_BIT_NEG_DONE])
      else $error("falling source did not clear flag");
   a_link_keeps: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      (!alt_release_mode_sel && flags[`PEI_BIT_LINKDOWN] && !reg_rd) |=> flags[`PEI_BIT_LINKDOWN])
      else $error("link down flag lost without read");
   a_alt_check_holds: assert property (@(posedge mclk) disable iff (rst) // [RQ14]
      (alt_release_mode_sel && flags[`PEI_BIT_RFAULT] && lvl[`PEI_BIT_RFAULT])
      |=> flags[`PEI_BIT_RFAULT])
      else $error("flag cleared while source high");
   a_alt_check_clears: assert property (@(posedge mclk) disable iff (rst) // [RQ14]
      (alt_release_mode_sel && reg_wr && reg_addr == `PEI_REG_EVENT_FLAGS
       && reg_wdata[`PEI_BIT_RFAULT] && !lvl[`PEI_BIT_RFAULT]) |=> !flags[`PEI_BIT_RFAULT])
      else $error("check write did not clear flag");
   a_alt_mask_release: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
      (alt_release_mode_sel && enables == 7'h00 && !late_pulse) |=> irq_out_low)
      else $error("masked output still low");
   a_neg_restart_clr: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
      (!alt_release_mode_sel && neg_restart && !rise[`PEI_BIT_PAGE] && !rise[`PEI_BIT_PDFAULT])
      |=> (!flags[`PEI_BIT_PAGE] && !flags[`PEI_BIT_PDFAULT]))
      else $error("page or fault flag kept after restart");
   a_link_down_clr: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
      (!alt_release_mode_sel && link_down_ev && !rise[`PEI_BIT_PAGE] && !rise[`PEI_BIT_PDFAULT])
      |=> (!flags[`PEI_BIT_PAGE] && !flags[`PEI_BIT_PDFAULT]))
      else $error("page or fault flag kept after link down");
   a_alt_no_fall_clr: assert property (@(posedge mclk) disable iff (rst) // [RQ15]
      (alt_release_mode_sel && !reg_wr && flags[`PEI_BIT_ACK]) |=> flags[`PEI_BIT_ACK])
      else $error("alt flag cleared without write");
   a_late_pulse_low: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
      late_pulse |=> !irq_out_low)
      else $error("late pulse not on output");
   a_rdata_pad: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
      $past(reg_rd) |-> (reg_rdata[15:8] == 8'h00 && !reg_rdata[0]))
      else $error("unused read bits not zero");
   c_alt_write: cover property (@(posedge mclk) alt_release_mode_sel && reg_wr);
   c_late: cover property (@(posedge mclk) late_pulse);
   c_irq: cover property (@(posedge mclk) !irq_out_low);
   c_flag_read: cover property (@(posedge mclk) reg_rd && reg_addr == `PEI_REG_EVENT_FLAGS);
   c_late_armed: cover property (@(posedge mclk) late_armed);
endmodule
`default_nettype wire

// ==== src/pei_defs.svh ====
// Purpose: offsets, field positions and timing counts of the phy event interrupt logic
// Assumes: register index space of the management interface, 16-bit registers
// Notes:   times in their own unit, cycle counts derived at 25 MHz
`ifndef PEI_DEFS_SVH
`define PEI_DEFS_SVH

`define PEI_REG_BASIC_STATUS  5'h01
`define PEI_REG_NEG_EXPANSION 5'h06
`define PEI_REG_EVENT_FLAGS   5'h1d
`define PEI_REG_ENABLE_BITS   5'h1e

`define PEI_BIT_ENERGY   3'h7
`define PEI_BIT_NEG_DONE 3'h6
`define PEI_BIT_RFAULT   3'h5
`define PEI_BIT_LINKDOWN 3'h4
`define PEI_BIT_ACK      3'h3
`define PEI_BIT_PDFAULT  3'h2
`define PEI_BIT_PAGE     3'h1

`define PEI_ENABLE_RESET 16'h0000

`define PEI_CLK_HZ          25000000
`define PEI_PULSE_MS        256
`define PEI_DELAY_MS        1000
`define PEI_MS_CYCLES       (`PEI_CLK_HZ / 1000)
`define PEI_PULSE_CYCLES    (`PEI_PULSE_MS * `PEI_MS_CYCLES)
`define PEI_DELAY_CYCLES    (`PEI_DELAY_MS * `PEI_MS_CYCLES)

`endif

// ==== src/pei_pkg.sv ====
// Purpose: shared types of the phy event interrupt logic
// Assumes: nothing beyond the defs header
// Notes:   one-hot states for the late energy pulse
package pei_pkg;
   typedef logic [7:1] pei_src_t;
   typedef enum logic [2:0] {
      PEI_LATE_IDLE  = 3'b001,
      PEI_LATE_WAIT  = 3'b010,
      PEI_LATE_PULSE = 3'b100
   } pei_late_t;
endpackage

// ==== src/pei_edge_sync.sv ====
// Purpose: two-flop synchroniser and edge detect for the seven sources
// Assumes: sources are asynchronous to mclk
// Notes:   first stage read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module pei_edge_sync (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire pei_pkg::pei_src_t src_async,
   output pei_pkg::pei_src_t      src_level,
   output pei_pkg::pei_src_t      src_rise,
   output pei_pkg::pei_src_t      src_fall
);
   import pei_pkg::*;
   pei_src_t meta;
   pei_src_t sync;
   pei_src_t last;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= 7'h00;
         sync <= 7'h00;
         last <= 7'h00;
      end else begin
         meta <= src_async;
         sync <= meta;
         last <= sync;
      end
   end

   assign src_level = sync;
   assign src_rise  = sync & ~last;
   assign src_fall  = ~sync & last;
endmodule
`default_nettype wire

// ==== testbench/pei_host_model.sv ====
// Purpose: host side model, register reads and writes on the strobe port
// Assumes: strobes sampled by the block at the rising edge of mclk
// Notes:   drives on the falling edge; idle bus shows inverted values
`timescale 1ns/100ps
`default_nettype none
module pei_host_model (
   input  wire logic        mclk,
   input  wire logic [15:0] reg_rdata,
   output logic             reg_rd,
   output logic             reg_wr,
   output logic [4:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   output logic             alt_release_mode_sel
);
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      alt_release_mode_sel = 1'b0;
   end
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask
   // alternate release only once software asks for it
   task automatic set_alt(input logic v);
      @(negedge mclk);
      alt_release_mode_sel = v;
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the phy event interrupt logic
// Assumes: short pulse and delay counts, 8 and 16 cycles
// Notes:   sources driven on the falling edge, all waits bounded
`timescale 1ns/100ps
`default_nettype none
`include "pei_defs.svh"
module tb_top;
   import pei_pkg::*;
   logic        mclk, rst, neg_restart, rd, wr, alt, irq_n;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, d;
   pei_src_t    src;
   int          fails, num_checks, n;
   pei_irq_logic #(.PULSE_CYCLES(8), .DELAY_CYCLES(16)) dut_u (.mclk(mclk), .rst(rst),
      .src_async(src), .neg_restart(neg_restart), .alt_release_mode_sel(alt), .reg_rd(rd),
      .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .irq_out_low(irq_n));
   pei_host_model host_u (.mclk(mclk), .reg_rdata(rdata), .reg_rd(rd), .reg_wr(wr),
      .reg_addr(addr), .reg_wdata(wdata), .alt_release_mode_sel(alt));
   always #20 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // wait long enough for synchroniser, flag and pin stages
   task automatic pin(input int w, input logic e);
      repeat (w) @(negedge mclk);
      chk({15'h0000, irq_n}, {15'h0000, e});
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
      host_u.rd(a, d);
      chk(d, e);
   endtask
   task automatic wait_pin(input logic e, output int k);
      k = 0;
      while (irq_n !== e) begin
         @(negedge mclk);
         k++;
         if (k > 100) begin
            fails++;
            wrap_up();
         end
      end
   endtask
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      src = 7'h00;
      neg_restart = 1'b0;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      pin(0, 1'b1);
      rdchk(`PEI_REG_ENABLE_BITS, 16'h0000);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0080);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0000);
      src[6] = 1'b1;
      pin(6, 1'b1);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0040);
      src[6] = 1'b0;
      host_u.wr(`PEI_REG_ENABLE_BITS, 16'h00fe);
      rdchk(`PEI_REG_ENABLE_BITS, 16'h00fe);
      for (int b = 1; b < 7; b++) begin
         if (b != 4) begin
            src[b] = 1'b1;
            pin(6, 1'b0);
            src[b] = 1'b0;
            pin(6, 1'b1);
         end
      end
      src[4] = 1'b1;
      pin(6, 1'b1);
      src[4] = 1'b0;
      pin(6, 1'b0);
      src[4] = 1'b1;
      pin(6, 1'b0);
      host_u.rd(`PEI_REG_BASIC_STATUS, d);
      pin(0, 1'b1);
      src[1] = 1'b1;
      pin(6, 1'b0);
      host_u.rd(`PEI_REG_NEG_EXPANSION, d);
      pin(0, 1'b1);
      src[2] = 1'b1;
      pin(6, 1'b0);
      neg_restart = 1'b1;
      @(negedge mclk);
      neg_restart = 1'b0;
      pin(1, 1'b1);
      src[2] = 1'b0;
      pin(6, 1'b1);
      src[2] = 1'b1;
      pin(6, 1'b0);
      src[4] = 1'b0;
      pin(6, 1'b0);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0010);
      src = 7'h08;
      pin(6, 1'b1);
      src = 7'h48;
      pin(6, 1'b0);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0080);
      pin(0, 1'b1);
      src[7] = 1'b0;
      wait_pin(1'b0, n);
      chk(16'(n >= 16 && n < 24), 16'h0001);
      wait_pin(1'b1, n);
      chk(16'(n), 16'h0008);
      host_u.wr(`PEI_REG_ENABLE_BITS, 16'h007e);
      host_u.set_alt(1'b1);
      src[5] = 1'b1;
      pin(6, 1'b0);
      host_u.wr(`PEI_REG_EVENT_FLAGS, 16'h0020);
      pin(2, 1'b0);
      src[5] = 1'b0;
      pin(6, 1'b0);
      host_u.wr(`PEI_REG_EVENT_FLAGS, 16'h0020);
      pin(2, 1'b1);
      src[4] = 1'b0;
      pin(6, 1'b0);
      host_u.wr(`PEI_REG_EVENT_FLAGS, 16'h0010);
      pin(2, 1'b0);
      src[4] = 1'b1;
      pin(6, 1'b0);
      host_u.wr(`PEI_REG_EVENT_FLAGS, 16'h0010);
      pin(2, 1'b1);
      src[3] = 1'b1;
      pin(6, 1'b0);
      host_u.wr(`PEI_REG_ENABLE_BITS, 16'h0000);
      pin(2, 1'b1);
      src[3] = 1'b0;
      pin(6, 1'b1);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0008);
      host_u.wr(`PEI_REG_EVENT_FLAGS, 16'h0008);
      rdchk(`PEI_REG_EVENT_FLAGS, 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
